// file: logic/spr_consts.svh
// Purpose: Offsets, field positions and reset values of the port registers
// Assumes: Included by the package user and the register set module
// Notes:   Definitions only
`ifndef SPR_CONSTS_SVH
`define SPR_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets (5-bit management register address)
// ----------------------------------------------------------------------
`define SPR_OFF_STATUS   5'h00
`define SPR_OFF_IDENT    5'h03
`define SPR_OFF_CTRL     5'h04
`define SPR_OFF_VLAN     5'h06
`define SPR_OFF_ASSOC    5'h0B
`define SPR_OFF_RXCNT    5'h10
`define SPR_OFF_TXCNT    5'h11

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SPR_ST_RESOLVED  13
`define SPR_ST_LINK      12
`define SPR_ST_KIND      11
`define SPR_ST_REVERSE   10
`define SPR_ST_DUPLEX    9
`define SPR_ST_SPEED     8
`define SPR_CT_PAUSE     15
`define SPR_CT_EGR_TRL   14
`define SPR_CT_HEADER    11
`define SPR_CT_ING_TRL   8
`define SPR_CT_TUNNEL    7
`define SPR_VM_DB_MSB    15
`define SPR_VM_DB_LSB    12
`define SPR_AV_IMON      15
`define SPR_STRAP_KIND   3
`define SPR_STRAP_REV    2

// ----------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------
`define SPR_MASK_ALL     6'h3F
`define SPR_SWMODE_CPU   2'h0
`define SPR_WORD_ZERO    16'h0000
`define SPR_CNT_ONE      16'h0001
`define SPR_NUM_PORTS    6

`endif

// file: logic/spr_pkg.sv
// Purpose: Types shared by the port register set and its users
// Assumes: Constants come from spr_consts.svh
// Notes:   Port state codes follow declaration order (00..11)
package spr_pkg;

  // --------------------------------------------------------------------
  // Spanning tree port state
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    SPR_ST_DISABLED,
    SPR_ST_BLOCKING,
    SPR_ST_LEARNING,
    SPR_ST_FORWARDING
  } spr_state_e;

  // --------------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------------
  typedef struct packed {
    logic link_up;
    logic resolved;
    logic duplex_full;
    logic speed_100;
  } spr_link_s;

  typedef struct packed {
    logic rx_good;
    logic rx_error;
    logic tx_good;
    logic tx_collision;
  } spr_evt_s;

  typedef struct packed {
    logic       force_pause_enable;
    logic       egress_trailer;
    logic       ingress_trailer;
    logic       locked_da_mask_bypass;
    logic       header_mode;
    logic       ingress_monitor;
    logic [3:0] default_database_number;
    logic [5:0] egress_port_mask;
    logic [5:0] learn_association_vector;
  } spr_ctrl_s;

  typedef struct packed {
    logic rx_allow;
    logic tx_allow;
    logic learn_allow;
    logic management_frame_only;
    logic return_buffers;
    logic duplex_full;
    logic speed_100;
  } spr_gate_s;

endpackage : spr_pkg

// file: logic/spr_port_regs.sv
// Purpose: Per-port register set of a six-port switch core
// Assumes: Management register access already decoded to this port
// Notes:   Straps are taken on the first clock after reset release
//
// Summary of operation
// - Status bit 12 shows live link
// - Interface kind reads 1, strap on CPU ports
// - Reverse bit 0, strap on ports 4, 5
// - Duplex bit read-only, writable on ports 4, 5
// - Speed bit valid when resolved, kind one
// - Identifier read-only: identity and revision
// - Force pause changes only while Disabled
// - Egress trailer enable, ports 4, 5 only
// - Ingress trailer enable, ports 4, 5 only
// - Tunnel bit bypasses mask for locked addresses
// - Disabled: no frames, buffers returned
// - Blocking: no learning, management frames only
// - Learning: learn, management frames only
// - Forwarding: learn, pass all frames
// - State resets Forwarding, Disabled in CPU mode
// - Counters hold when Disabled, clear on mode change
// - Four-bit default database number stored
// - Egress mask resets all ones except own
// - Association vector zero disables learning
// - Ingress monitor copies entering frames
// - Receive counter: good or error frames
// - Transmit counter: good frames or collisions
// - Resolved flag zero while disabled
// - Reserved bits and offsets read zero
`timescale 1ns/1ps
`include "spr_consts.svh"

module spr_port_regs #(
  parameter int unsigned  PORT_NUM  = 0,
  parameter logic [11:0]  PART_ID   = 12'hA5C,  // Arbitrary value
  parameter logic [3:0]   SILICON_REV = 4'h1    // Arbitrary value
) (
  // Clock and reset
  input  wire logic               mclk_in,
  input  wire logic               rst_in,
  // Register access
  input  wire logic [4:0]         reg_addr_in,
  input  wire logic               reg_wr_in,
  input  wire logic               reg_rd_in,
  input  wire logic [15:0]        reg_wdata_in,
  output logic      [15:0]        rd_data_out,
  output logic                    rd_valid_out,
  // Straps and global controls
  input  wire logic [3:0]         cpu_port_straps_in,
  input  wire logic [1:0]         switch_mode_straps_in,
  input  wire logic               switch_soft_reset_in,
  input  wire logic               counter_mode_select_in,
  // Port activity
  input  wire spr_pkg::spr_link_s link_in,
  input  wire spr_pkg::spr_evt_s  evt_in,
  // Controls to the datapath
  output spr_pkg::spr_ctrl_s      ctrl_out,
  output spr_pkg::spr_gate_s      gate_out
);
  import spr_pkg::*;

  // --------------------------------------------------------------------
  // Elaboration checks and constants
  // --------------------------------------------------------------------
  if (PORT_NUM >= `SPR_NUM_PORTS) begin : g_bad_port
    $error("PORT_NUM must be 0 to 5");
  end

  localparam logic [5:0] OWN_BIT = 6'(6'h01 << PORT_NUM);
  localparam logic       IS_CPU  = (PORT_NUM >= 4);

  function automatic spr_state_e init_state(input logic cpu_mode);
    init_state = cpu_mode ? SPR_ST_DISABLED : SPR_ST_FORWARDING;
  endfunction : init_state

  spr_state_e  state_r;
  spr_ctrl_s   ctrl_r;
  spr_gate_s   gate_r;
  logic        taken_r;
  logic        cpu_mode_r;
  logic        kind_r;
  logic        reverse_r;
  logic        dup_set_r;
  logic        dup_wr_r;
  logic        mode_prev_r;
  logic [15:0] rx_cnt_r;
  logic [15:0] tx_cnt_r;
  logic [15:0] rd_data_r;
  logic        rd_valid_r;
  logic        wr_ctrl;
  logic        mode_chg;
  logic        rx_inc;
  logic        tx_inc;
  logic        duplex_rd;
  logic        resolved_rd;
  logic [15:0] rd_data_nxt;

  assign wr_ctrl  = reg_wr_in && (reg_addr_in == `SPR_OFF_CTRL);
  assign mode_chg = counter_mode_select_in != mode_prev_r;

  // --------------------------------------------------------------------
  // Straps, taken after release so reset stays constant
  // --------------------------------------------------------------------
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      taken_r    <= 1'b0;
      cpu_mode_r <= 1'b0;
      kind_r     <= 1'b1;
      reverse_r  <= 1'b0;
    end else if (!taken_r) begin
      taken_r    <= 1'b1;
      cpu_mode_r <= (switch_mode_straps_in == `SPR_SWMODE_CPU);
      kind_r     <= IS_CPU ? cpu_port_straps_in[`SPR_STRAP_KIND]
                           : 1'b1;
      reverse_r  <= IS_CPU ? cpu_port_straps_in[`SPR_STRAP_REV]
                           : 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Port state
  // --------------------------------------------------------------------
  // Held Disabled until straps are known, so no frame slips through
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= SPR_ST_DISABLED;
    end else if (!taken_r) begin
      state_r <= init_state(switch_mode_straps_in == `SPR_SWMODE_CPU);
    end else if (switch_soft_reset_in) begin
      state_r <= init_state(cpu_mode_r);
    end else if (wr_ctrl) begin
      state_r <= spr_state_e'(reg_wdata_in[1:0]);
    end
  end

  // --------------------------------------------------------------------
  // Port control fields
  // --------------------------------------------------------------------
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_r.force_pause_enable    <= 1'b0;
      ctrl_r.egress_trailer        <= 1'b0;
      ctrl_r.ingress_trailer       <= 1'b0;
      ctrl_r.locked_da_mask_bypass <= 1'b0;
      ctrl_r.header_mode           <= 1'b0;
    end else if (wr_ctrl) begin
      if (state_r == SPR_ST_DISABLED) begin
        ctrl_r.force_pause_enable <= reg_wdata_in[`SPR_CT_PAUSE];
      end
      ctrl_r.egress_trailer <= IS_CPU &&
                               reg_wdata_in[`SPR_CT_EGR_TRL];
      ctrl_r.ingress_trailer <= IS_CPU &&
                                reg_wdata_in[`SPR_CT_ING_TRL];
      ctrl_r.locked_da_mask_bypass <= reg_wdata_in[`SPR_CT_TUNNEL];
      ctrl_r.header_mode <= reg_wdata_in[`SPR_CT_HEADER];
    end
  end

  // --------------------------------------------------------------------
  // VLAN map and association vector
  // --------------------------------------------------------------------
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_r.default_database_number  <= 4'h0;
      ctrl_r.egress_port_mask         <= `SPR_MASK_ALL & ~OWN_BIT;
      ctrl_r.ingress_monitor          <= 1'b0;
      ctrl_r.learn_association_vector <= OWN_BIT;
    end else if (reg_wr_in) begin
      if (reg_addr_in == `SPR_OFF_VLAN) begin
        ctrl_r.default_database_number <=
          reg_wdata_in[`SPR_VM_DB_MSB:`SPR_VM_DB_LSB];
        ctrl_r.egress_port_mask <= reg_wdata_in[5:0];
      end
      if (reg_addr_in == `SPR_OFF_ASSOC) begin
        ctrl_r.ingress_monitor <= reg_wdata_in[`SPR_AV_IMON];
        ctrl_r.learn_association_vector <= reg_wdata_in[5:0];
      end
    end
  end

  // --------------------------------------------------------------------
  // Duplex override on CPU ports
  // --------------------------------------------------------------------
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      dup_set_r <= 1'b0;
      dup_wr_r  <= 1'b0;
    end else if (IS_CPU && reg_wr_in &&
                 reg_addr_in == `SPR_OFF_STATUS) begin
      dup_set_r <= 1'b1;
      dup_wr_r  <= reg_wdata_in[`SPR_ST_DUPLEX];
    end
  end

  assign duplex_rd   = dup_set_r ? dup_wr_r : link_in.duplex_full;
  assign resolved_rd = link_in.resolved &&
                       (state_r != SPR_ST_DISABLED);

  // --------------------------------------------------------------------
  // Datapath gates from the port state
  // --------------------------------------------------------------------
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      gate_r <= '0;
    end else begin
      unique case (state_r)
        SPR_ST_DISABLED: begin
          gate_r.rx_allow              <= 1'b0;
          gate_r.tx_allow              <= 1'b0;
          gate_r.learn_allow           <= 1'b0;
          gate_r.management_frame_only <= 1'b0;
          gate_r.return_buffers        <= 1'b1;
        end
        SPR_ST_BLOCKING: begin
          gate_r.rx_allow              <= 1'b1;
          gate_r.tx_allow              <= 1'b1;
          gate_r.learn_allow           <= 1'b0;
          gate_r.management_frame_only <= 1'b1;
          gate_r.return_buffers        <= 1'b0;
        end
        SPR_ST_LEARNING: begin
          gate_r.rx_allow              <= 1'b1;
          gate_r.tx_allow              <= 1'b1;
          gate_r.learn_allow <= |ctrl_r.learn_association_vector;
          gate_r.management_frame_only <= 1'b1;
          gate_r.return_buffers        <= 1'b0;
        end
        SPR_ST_FORWARDING: begin
          gate_r.rx_allow              <= 1'b1;
          gate_r.tx_allow              <= 1'b1;
          gate_r.learn_allow <= |ctrl_r.learn_association_vector;
          gate_r.management_frame_only <= 1'b0;
          gate_r.return_buffers        <= 1'b0;
        end
      endcase
      gate_r.duplex_full <= duplex_rd;
      // SNI ports always run at 10 Mbps
      gate_r.speed_100 <= resolved_rd && kind_r &&
                          link_in.speed_100;
    end
  end

  // --------------------------------------------------------------------
  // Frame counters
  // --------------------------------------------------------------------
  assign rx_inc = (state_r != SPR_ST_DISABLED) &&
                  (counter_mode_select_in ? evt_in.rx_error
                                          : evt_in.rx_good);
  assign tx_inc = (state_r != SPR_ST_DISABLED) &&
                  (counter_mode_select_in ? evt_in.tx_collision
                                          : evt_in.tx_good);

  // Mode change clears and wins over a frame in the same cycle
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      mode_prev_r <= 1'b0;
      rx_cnt_r    <= `SPR_WORD_ZERO;
      tx_cnt_r    <= `SPR_WORD_ZERO;
    end else begin
      mode_prev_r <= counter_mode_select_in;
      if (mode_chg) begin
        rx_cnt_r <= `SPR_WORD_ZERO;
        tx_cnt_r <= `SPR_WORD_ZERO;
      end else begin
        if (rx_inc) begin
          rx_cnt_r <= rx_cnt_r + `SPR_CNT_ONE;
        end
        if (tx_inc) begin
          tx_cnt_r <= tx_cnt_r + `SPR_CNT_ONE;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------
  // Only the decoded fields are placed; all else stays zero
  always_comb begin
    rd_data_nxt = `SPR_WORD_ZERO;
    unique case (reg_addr_in)
      `SPR_OFF_STATUS: begin
        rd_data_nxt[`SPR_ST_RESOLVED] = resolved_rd;
        rd_data_nxt[`SPR_ST_LINK]     = link_in.link_up;
        rd_data_nxt[`SPR_ST_KIND]     = kind_r;
        rd_data_nxt[`SPR_ST_REVERSE]  = reverse_r;
        rd_data_nxt[`SPR_ST_DUPLEX]   = duplex_rd;
        rd_data_nxt[`SPR_ST_SPEED]    = link_in.speed_100;
      end
      `SPR_OFF_IDENT: begin
        rd_data_nxt = {PART_ID, SILICON_REV};
      end
      `SPR_OFF_CTRL: begin
        rd_data_nxt[`SPR_CT_PAUSE]   = ctrl_r.force_pause_enable;
        rd_data_nxt[`SPR_CT_EGR_TRL] = ctrl_r.egress_trailer;
        rd_data_nxt[`SPR_CT_HEADER]  = ctrl_r.header_mode;
        rd_data_nxt[`SPR_CT_ING_TRL] = ctrl_r.ingress_trailer;
        rd_data_nxt[`SPR_CT_TUNNEL]  = ctrl_r.locked_da_mask_bypass;
        rd_data_nxt[1:0]             = state_r;
      end
      `SPR_OFF_VLAN: begin
        rd_data_nxt[`SPR_VM_DB_MSB:`SPR_VM_DB_LSB] =
          ctrl_r.default_database_number;
        rd_data_nxt[5:0] = ctrl_r.egress_port_mask;
      end
      `SPR_OFF_ASSOC: begin
        rd_data_nxt[`SPR_AV_IMON] = ctrl_r.ingress_monitor;
        rd_data_nxt[5:0]          = ctrl_r.learn_association_vector;
      end
      `SPR_OFF_RXCNT: rd_data_nxt = rx_cnt_r;
      `SPR_OFF_TXCNT: rd_data_nxt = tx_cnt_r;
      default:        rd_data_nxt = `SPR_WORD_ZERO;
    endcase
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_r  <= `SPR_WORD_ZERO;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= reg_rd_in;
      if (reg_rd_in) begin
        rd_data_r <= rd_data_nxt;
      end
    end
  end

  assign rd_data_out  = rd_data_r;
  assign rd_valid_out = rd_valid_r;
  assign ctrl_out     = ctrl_r;
  assign gate_out     = gate_r;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  a_link_live_read:
  assert property (@(posedge mclk_in) disable iff (rst_in)
    (reg_rd_in && reg_addr_in == `SPR_OFF_STATUS) |=>
      rd_valid_out && rd_data_out[`SPR_ST_LINK] == $past(link_in.link_up))
    else $error("link bit does not follow link input");

  a_kind_phy_port:
  assert property (@(posedge mclk_in) disable iff (rst_in)
    (!IS_CPU && reg_rd_in && reg_addr_in == `SPR_OFF_STATUS) |=>
      rd_data_out[`SPR_ST_KIND] && !rd_data_out[`SPR_ST_REVERSE])
    else $error("interface kind or reverse bit wrong on phy port");

  a_ident_read:
  assert property (@(posedge mclk_in) disable iff (rst_in)
    (reg_rd_in && reg_addr_in == `SPR_OFF_IDENT) |=>
      rd_data_out == {PART_ID, SILICON_REV})
    else $error("identifier read wrong");

  a_pause_locked:
  assert property (@(posedge mclk_in) disable iff (rst_in)
    (wr_ctrl && state_r != SPR_ST_DISABLED) |=>
      $stable(ctrl_out.force_pause_enable))
    else $error("force pause changed outside disabled state");

  a_disabled_gate:
  assert property (@(posedge mclk_in) disable iff (rst_in)
    (state_r == SPR_ST_DISABLED) |=>
      !gate_out.rx_allow && !gate_out.tx_allow && gate_out.return_buffers)
    else $error("disabled port still passes frames");

  a_soft_reset_state:
  assert property (@(posedge mclk_in) disable iff (rst_in)
    (taken_r && switch_soft_reset_in) |=>
      state_r == (cpu_mode_r ? SPR_ST_DISABLED : SPR_ST_FORWARDING))
    else $error("soft reset left wrong port state");

  a_counter_clear:
  assert property (@(posedge mclk_in) disable iff (rst_in)
    mode_chg |=> rx_cnt_r == `SPR_WORD_ZERO && tx_cnt_r == `SPR_WORD_ZERO)
    else $error("counters not cleared on mode change");

  a_disabled_hold:
  assert property (@(posedge mclk_in) disable iff (rst_in)
    (state_r == SPR_ST_DISABLED && !mode_chg)[*2] |->
      $stable(rx_cnt_r) && $stable(tx_cnt_r))
    else $error("counter moved while disabled");

  a_rx_count_step:
  assert property (@(posedge mclk_in) disable iff (rst_in)
    (!mode_chg && !counter_mode_select_in && evt_in.rx_good &&
     state_r != SPR_ST_DISABLED) |=>
      rx_cnt_r == $past(rx_cnt_r) + `SPR_CNT_ONE)
    else $error("receive counter did not step");

  a_reserved_zero:
  assert property (@(posedge mclk_in) disable iff (rst_in)
    (reg_rd_in && (reg_addr_in == 5'h01 || reg_addr_in == 5'h12)) |=>
      rd_data_out == `SPR_WORD_ZERO)
    else $error("reserved offset read non-zero");

endmodule : spr_port_regs

// file: sim/spr_management_frame_master.sv
// Purpose: Management master model driving the port register bus
// Assumes: One-cycle strobes, answer one cycle after the strobe
// Notes:   Write data is inverted once released, never left stale
`timescale 1ns/1ps
module spr_management_frame_master (
  // Clock
  input  wire logic        clk_in,
  // Register bus
  output logic      [4:0]  addr_out,
  output logic             wr_out,
  output logic             rd_out,
  output logic      [15:0] wdata_out,
  input  wire logic [15:0] rdata_in,
  input  wire logic        rvalid_in
);
  initial begin
    addr_out  = 5'h00;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
    wdata_out = 16'h0000;
  end

  // Callers change pause only while Disabled, the vector also while Forwarding
  task automatic write_reg(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk_in);
    addr_out  = a;
    wdata_out = d;
    wr_out    = 1'b1;
    @(negedge clk_in);
    wr_out    = 1'b0;
    wdata_out = ~d;
  endtask : write_reg

  // Answer stands one cycle only, so it is looked at in that cycle
  task automatic read_reg(input logic [4:0] a, output logic [15:0] d,
                          output logic ok);
    @(negedge clk_in);
    addr_out = a;
    rd_out   = 1'b1;
    @(negedge clk_in);
    rd_out   = 1'b0;
    ok = (rvalid_in === 1'b1);
    d  = rdata_in;
  endtask : read_reg
endmodule : spr_management_frame_master

// file: sim/switch_port_register_set_tb.sv
// Purpose: Self-checking bench for the port register set, port 4
// Assumes: Inputs driven on the falling edge, LFSR seeded with 49
// Notes:   Ends with a second reset in CPU-attached mode
`timescale 1ns/1ps
module switch_port_register_set_tb;
  import spr_pkg::*;
  localparam logic [11:0] ID  = 12'h3C7;  // Arbitrary value
  localparam logic [3:0]  REV = 4'h9;     // Arbitrary value
  logic        mclk_in = 1'b0;
  logic        rst_in  = 1'b1;
  logic [4:0]  addr;
  logic        wr, rd, rvalid, ok;
  logic [15:0] wdata, rdata, word, rnd = 16'h0031;
  logic        cmode = 1'b0, sreset = 1'b0;
  logic [1:0]  swmode = 2'h1;
  logic [3:0]  straps = 4'hC;
  logic [15:0] rdata_phy;
  spr_link_s   link = '0;
  spr_evt_s    evt  = '0;
  spr_ctrl_s   ctrl;
  spr_gate_s   gate;
  int          num_errors = 0, cmp_count = 0, n;
  logic [4:0]  rsv [4] = '{5'h01, 5'h05, 5'h0C, 5'h1F};

  always #2 mclk_in = ~mclk_in;

  spr_port_regs #(.PORT_NUM(4), .PART_ID(ID), .SILICON_REV(REV)) i_dut (
    .mclk_in(mclk_in), .rst_in(rst_in), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
    .rd_data_out(rdata), .rd_valid_out(rvalid),
    .cpu_port_straps_in(straps), .switch_mode_straps_in(swmode),
    .switch_soft_reset_in(sreset), .counter_mode_select_in(cmode),
    .link_in(link), .evt_in(evt), .ctrl_out(ctrl), .gate_out(gate));

  // Port with a PHY on the same bus, so its own assertions run too
  spr_port_regs #(.PORT_NUM(1)) i_dut_phy (
    .mclk_in(mclk_in), .rst_in(rst_in), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
    .rd_data_out(rdata_phy), .rd_valid_out(),
    .cpu_port_straps_in(straps), .switch_mode_straps_in(swmode),
    .switch_soft_reset_in(sreset), .counter_mode_select_in(cmode),
    .link_in(link), .evt_in(evt), .ctrl_out(), .gate_out());

  spr_management_frame_master i_mst (.clk_in(mclk_in), .addr_out(addr), .wr_out(wr),
    .rd_out(rd), .wdata_out(wdata), .rdata_in(rdata), .rvalid_in(rvalid));

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr

  function automatic logic [15:0] st(input logic dis, input logic dup);
    return {2'h0, link.resolved & ~dis, link.link_up, straps[3:2], dup,
            link.speed_100, 8'h00};
  endfunction : st

  // Order rx, tx, learn, management only, return buffers
  function automatic logic [4:0] exp_gate(input int s);
    case (s)
      0:       return 5'h01;
      1:       return 5'h1A;
      2:       return 5'h1E;
      default: return 5'h1C;
    endcase
  endfunction : exp_gate

  task automatic end_of_test;
    $display("Comparisons %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test

  task automatic chk_word(input string nm, input logic [15:0] e, g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word

  task automatic chk_gate(input int s);
    cmp_count++;
    if ({gate.rx_allow, gate.tx_allow, gate.learn_allow,
        gate.management_frame_only, gate.return_buffers} !== exp_gate(s))
    begin
      num_errors++;
      $display("MISMATCH gate_out state %0d expected %h seen %h", s,
               exp_gate(s), gate);
    end
  endtask : chk_gate

  task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
    i_mst.read_reg(a, word, ok);
    chk_word("rd_valid_out", 16'h0001, {15'h0000, ok});
    chk_word($sformatf("register %h", a), e, word);
  endtask : rd_chk

  task automatic pulse(input logic [3:0] e, input int k);
    repeat (k) begin
      @(negedge mclk_in);
      evt = spr_evt_s'(e);
      @(negedge mclk_in);
      evt = '0;
    end
  endtask : pulse

  initial begin
    #100000;
    num_errors++;
    end_of_test();
  end

  initial begin
    repeat (8) @(posedge mclk_in);
    @(negedge mclk_in);
    rst_in = 1'b0;
    repeat (2) @(negedge mclk_in);
    rd_chk(5'h04, 16'h0003);
    rd_chk(5'h06, 16'h002F);
    chk_word("phy rd_data_out", 16'h003D, rdata_phy);
    rd_chk(5'h0B, 16'h0010);
    foreach (rsv[i]) rd_chk(rsv[i], 16'h0000);
    for (int i = 0; i < 6; i++) begin
      rnd  = lfsr(rnd);
      link = spr_link_s'(rnd[3:0]);
      rd_chk(5'h00, st(1'b0, link.duplex_full));
      chk_word("gate_out", {14'h0000, link.duplex_full,
        link.resolved & link.speed_100}, {14'h0000, gate.duplex_full,
        gate.speed_100});
    end
    i_mst.write_reg(5'h03, 16'hFFFF);
    rd_chk(5'h03, {ID, REV});
    i_mst.write_reg(5'h10, 16'h5A5A);
    rd_chk(5'h10, 16'h0000);
    i_mst.write_reg(5'h04, 16'hC983);
    rd_chk(5'h04, 16'h4983);
    chk_word("ctrl_out", 16'h000F, {12'h000, ctrl.egress_trailer,
      ctrl.ingress_trailer, ctrl.locked_da_mask_bypass, ctrl.header_mode});
    i_mst.write_reg(5'h04, 16'h4980);
    i_mst.write_reg(5'h04, 16'hC980);
    rd_chk(5'h04, 16'hC980);
    chk_word("pause", 16'h0001, {15'h0000, ctrl.force_pause_enable});
    rd_chk(5'h00, st(1'b1, link.duplex_full));
    pulse(4'hF, 3);
    rd_chk(5'h10, 16'h0000);
    for (int s = 0; s < 4; s++) begin
      i_mst.write_reg(5'h04, 16'hC980 | 16'(s));
      repeat (2) @(negedge mclk_in);
      chk_gate(s);
    end
    rnd = lfsr(rnd);
    n   = int'(rnd[2:0]) + 1;
    pulse(4'hA, n);
    pulse(4'h5, 2);
    rd_chk(5'h10, 16'(n));
    rd_chk(5'h11, 16'(n));
    @(negedge mclk_in);
    cmode = 1'b1;
    rd_chk(5'h11, 16'h0000);
    pulse(4'h5, 3);
    pulse(4'hA, 1);
    rd_chk(5'h10, 16'h0003);
    rd_chk(5'h11, 16'h0003);
    i_mst.write_reg(5'h0B, 16'h0000);
    repeat (2) @(negedge mclk_in);
    chk_word("learn", 16'h0000, {15'h0000, gate.learn_allow});
    i_mst.write_reg(5'h0B, 16'hFFFF);
    rd_chk(5'h0B, 16'h803F);
    chk_word("monitor", 16'h0001, {15'h0000, ctrl.ingress_monitor});
    rnd = lfsr(rnd);
    i_mst.write_reg(5'h06, rnd);
    rd_chk(5'h06, rnd & 16'hF03F);
    chk_word("vlan", rnd & 16'hF03F, {ctrl.default_database_number, 6'h00,
      ctrl.egress_port_mask});
    i_mst.write_reg(5'h00, {6'h00, ~link.duplex_full, 9'h000});
    rd_chk(5'h00, st(1'b0, ~link.duplex_full));
    i_mst.write_reg(5'h04, 16'hC981);
    @(negedge mclk_in);
    sreset = 1'b1;
    @(negedge mclk_in);
    sreset = 1'b0;
    rd_chk(5'h04, 16'hC983);
    // Second reset in CPU-attached mode, SNI straps, port comes up Disabled
    rst_in = 1'b1;
    swmode = 2'h0;
    straps = 4'h3;
    link   = spr_link_s'(4'hF);
    repeat (3) @(negedge mclk_in);
    rst_in = 1'b0;
    repeat (2) @(negedge mclk_in);
    rd_chk(5'h04, 16'h0000);
    rd_chk(5'h00, st(1'b1, 1'b1));
    end_of_test();
  end
endmodule : switch_port_register_set_tb
